// >>> rtl/wbdelay_core.sv
// Work-bit logic with ON/OFF delays, event slot routing and bank selection behind an APB slave.
`timescale 1ns/1ps
`default_nettype none
module wbdelay_core import wbdelay_pkg::*; #(
    parameter int unsigned SEC_CYCLES = SEC_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [EV_N-1:0] ev_pin,
    input wire logic [COND_N-1:0] cond_in,
    output logic [WB_N-1:0] work_bit,
    output logic [EV_N-1:0] event_slot,
    output logic [2:0] bank_no,
    output logic bank_sel_en,
    output logic [EV_N-1:0] assign_visible,
    output logic [1:0] ctrl_out,
    output logic aux_out,
    output logic [2:0] alarm_assigned
);
    // ----------------------------------------------------------------
    // Source selection helpers
    // ----------------------------------------------------------------
    function automatic logic src_bit(input logic [5:0] code, input logic [EV_N-1:0] ev,
                                     input logic [COND_N-1:0] cond, input logic [WB_N-1:0] wb, input logic pwr);
        logic [5:0] o;
        o = code;
        if (code == SRC_ON) begin
            src_bit = 1'b1;
        end else if (code == SRC_PWR) begin
            src_bit = pwr;
        end else if (code >= SRC_WB_FIRST) begin
            o = code - SRC_WB_FIRST;
            src_bit = wb[o[2:0]];
        end else if (code >= SRC_COND_FIRST) begin
            o = code - SRC_COND_FIRST;
            src_bit = cond[o[4:0]];
        end else if (code >= SRC_EV_FIRST) begin
            o = code - SRC_EV_FIRST;
            src_bit = ev[o[1:0]];
        end else begin
            src_bit = 1'b0;
        end
    endfunction : src_bit

    function automatic logic slot_bit(input logic [3:0] code, input logic [EV_N-1:0] ev, input logic [WB_N-1:0] wb);
        logic [3:0] o;
        o = code;
        if (code >= EV_WB_FIRST) begin
            o = code - EV_WB_FIRST;
            slot_bit = wb[o[2:0]];
        end else if (code != EV_NONE) begin
            o = code - EV_EXT_FIRST;
            slot_bit = ev[o[1:0]];
        end else begin
            slot_bit = 1'b0;
        end
    endfunction : slot_bit

    // ----------------------------------------------------------------
    // Event pin synchroniser
    // ----------------------------------------------------------------
    logic [EV_N-1:0] ev_s1, ev_s2, ev_s3, ev_clean, next_ev_clean;
    logic first_cycle;
    always_comb begin
        next_ev_clean = (ev_s2 & ev_s3) | (ev_clean & (ev_s2 | ev_s3));
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ev_s1 <= '0;
            ev_s2 <= '0;
            ev_s3 <= '0;
            ev_clean <= '0;
            first_cycle <= 1'b1;
        end else begin
            ev_s1 <= ev_pin;
            ev_s2 <= ev_s1;
            ev_s3 <= ev_s2;
            ev_clean <= next_ev_clean;
            first_cycle <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Register file and APB slave
    // ----------------------------------------------------------------
    logic time_unit, no_ev12, two_ev;
    logic [1:0] bank_count;
    logic [EV_N-1:0][3:0] evdata, evfunc;
    logic [OUT_N-1:0][3:0] outsel;
    wb_cfg_s cfg [WB_N];
    wb_dly_s dly [WB_N];
    logic next_time_unit, next_no_ev12, next_two_ev, next_pready, next_pslverr;
    logic [1:0] next_bank_count;
    logic [EV_N-1:0][3:0] next_evdata, next_evfunc;
    logic [OUT_N-1:0][3:0] next_outsel;
    wb_cfg_s next_cfg [WB_N];
    wb_dly_s next_dly [WB_N];
    logic [31:0] next_prdata, rd, status_word;
    logic err, fire, any_wb_slot, any_comm;
    logic [2:0] idx;
    wb_cfg_s wcfg;
    wb_dly_s wdly;
    logic [EV_N-1:0][3:0] wnib;

    always_comb begin
        idx = paddr[4:2];
        wcfg = wb_cfg_s'(pwdata);
        wdly = wb_dly_s'(pwdata);
        wnib = pwdata[15:0];
        fire = psel && penable && pready && !pslverr;
        any_wb_slot = 1'b0;
        any_comm = 1'b0;
        for (int s = 0; s < EV_N; s++) begin
            any_wb_slot = any_wb_slot | (evdata[s] >= EV_WB_FIRST);
            any_comm = any_comm | (evfunc[s] == FUNC_COMM_WR);
        end
        rd = 32'h0000_0000;
        err = 1'b0;
        if (paddr == OFF_CTRL) begin
            rd = {27'h000_0000, two_ev, no_ev12, bank_count, time_unit};
            err = pwrite && (pwdata[CTRL_BANK_LSB+:2] > (pwdata[CTRL_TWOEV] ? BANK_MAX_TWO : BANK_MAX));
        end else if (paddr == OFF_EVDATA) begin
            rd = {16'h0000, evdata};
            for (int s = 0; s < EV_N; s++) begin
                err = err | (pwrite && wnib[s] > EV_WB_LAST);
                err = err | (pwrite && wnib[s] >= EV_WB_FIRST && any_comm);
            end
        end else if (paddr == OFF_EVFUNC) begin
            rd = {16'h0000, evfunc};
            for (int s = 0; s < EV_N; s++) begin
                err = err | (pwrite && wnib[s] == FUNC_COMM_WR && any_wb_slot);
                err = err | (pwrite && wnib[s] != evfunc[s] && !assign_visible[s]);
            end
        end else if (paddr == OFF_OUTSEL) begin
            rd = {20'h0_0000, outsel};
            for (int k = 0; k < OUT_N; k++) begin
                err = err | (pwrite && pwdata[4*k+:4] > OUT_WB_LAST);
            end
        end else if (paddr == OFF_STATUS) begin
            rd = status_word;
            err = pwrite;
        end else if ((paddr & OFF_BLOCK_MASK) == OFF_CFG) begin
            rd = cfg[idx];
            err = pwrite && (wcfg.op > OP_ALL || wcfg.sel_a > SRC_WB_LAST || wcfg.sel_b > SRC_WB_LAST
                             || wcfg.sel_c > SRC_WB_LAST || wcfg.sel_d > SRC_WB_LAST);
        end else if ((paddr & OFF_BLOCK_MASK) == OFF_DLY) begin
            rd = {2'h0, dly[idx].off_dly, 2'h0, dly[idx].on_dly};
            err = pwrite && (wdly.on_dly > DLY_MAX || wdly.off_dly > DLY_MAX);
        end else begin
            err = 1'b1;
        end
        next_pready = psel && penable && !pready;
        next_pslverr = next_pready && err;
        next_prdata = (next_pready && !pwrite) ? rd : prdata;
        next_time_unit = time_unit;
        next_bank_count = bank_count;
        next_no_ev12 = no_ev12;
        next_two_ev = two_ev;
        next_evdata = evdata;
        next_evfunc = evfunc;
        next_outsel = outsel;
        next_cfg = cfg;
        next_dly = dly;
        // Refused writes leave every setting untouched; the error shows on pslverr.
        if (fire && pwrite) begin
            if (paddr == OFF_CTRL) begin
                next_time_unit = pwdata[CTRL_UNIT];
                next_bank_count = pwdata[CTRL_BANK_LSB+:2];
                next_no_ev12 = pwdata[CTRL_NOEV12];
                next_two_ev = pwdata[CTRL_TWOEV];
            end else if (paddr == OFF_EVDATA) begin
                next_evdata = wnib;
            end else if (paddr == OFF_EVFUNC) begin
                next_evfunc = wnib;
            end else if (paddr == OFF_OUTSEL) begin
                next_outsel = pwdata[4*OUT_N-1:0];
            end else if ((paddr & OFF_BLOCK_MASK) == OFF_CFG) begin
                next_cfg[idx] = wcfg;
            end else begin
                next_dly[idx] = {2'h0, wdly.off_dly, 2'h0, wdly.on_dly};
            end
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            time_unit <= 1'b0;
            bank_count <= 2'h0;
            no_ev12 <= 1'b0;
            two_ev <= 1'b0;
            evdata <= EVDATA_RST;
            evfunc <= '0;
            outsel <= '0;
            for (int i = 0; i < WB_N; i++) begin
                cfg[i] <= '0;
                dly[i] <= '0;
            end
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            time_unit <= next_time_unit;
            bank_count <= next_bank_count;
            no_ev12 <= next_no_ev12;
            two_ev <= next_two_ev;
            evdata <= next_evdata;
            evfunc <= next_evfunc;
            outsel <= next_outsel;
            cfg <= next_cfg;
            dly <= next_dly;
        end
    end

    // ----------------------------------------------------------------
    // Time base
    // ----------------------------------------------------------------
    // The tick runs freely, so the first unit of a delay may be partial: a setting of N
    // gives between N-1 and N whole units. A per-bit prescaler would cost far more flops.
    logic [SEC_CNT_W-1:0] sec_cnt, next_sec_cnt;
    logic [5:0] min_cnt, next_min_cnt;
    logic sec_tick, unit_tick;
    always_comb begin
        sec_tick = sec_cnt == SEC_CNT_W'(SEC_CYCLES - 1);
        next_sec_cnt = sec_tick ? '0 : sec_cnt + 1'b1;
        next_min_cnt = min_cnt;
        if (sec_tick) begin
            next_min_cnt = (min_cnt == MIN_SECS - 6'h01) ? 6'h00 : min_cnt + 6'h01;
        end
        unit_tick = sec_tick && (!time_unit || min_cnt == MIN_SECS - 6'h01);
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sec_cnt <= '0;
            min_cnt <= 6'h00;
        end else begin
            sec_cnt <= next_sec_cnt;
            min_cnt <= next_min_cnt;
        end
    end

    // ----------------------------------------------------------------
    // Work bits and delays
    // ----------------------------------------------------------------
    logic [WB_N-1:0] raw_v, next_work_bit;
    logic [DLY_W-1:0] cnt [WB_N];
    logic [DLY_W-1:0] next_cnt [WB_N];
    always_comb begin
        logic [3:0] in_v;
        logic comb_v;
        logic [DLY_W-1:0] lim;
        in_v = 4'h0;
        comb_v = 1'b0;
        lim = DLY_RST;
        next_work_bit = work_bit;
        next_cnt = cnt;
        for (int i = 0; i < WB_N; i++) begin
            in_v[0] = src_bit(cfg[i].sel_a, ev_clean, cond_in, work_bit, first_cycle);
            in_v[1] = src_bit(cfg[i].sel_b, ev_clean, cond_in, work_bit, first_cycle);
            in_v[2] = src_bit(cfg[i].sel_c, ev_clean, cond_in, work_bit, first_cycle);
            in_v[3] = src_bit(cfg[i].sel_d, ev_clean, cond_in, work_bit, first_cycle);
            in_v = in_v ^ cfg[i].in_nc;
            unique case (cfg[i].op)
                OP_OFF: comb_v = 1'b0;
                OP_AB_OR_CD: comb_v = (in_v[0] & in_v[1]) | (in_v[2] & in_v[3]);
                OP_AC_AND_BD: comb_v = (in_v[0] | in_v[2]) & (in_v[1] | in_v[3]);
                OP_ANY: comb_v = |in_v;
                OP_ALL: comb_v = &in_v;
                default: comb_v = 1'b0;
            endcase
            raw_v[i] = comb_v ^ cfg[i].out_nc;
            lim = raw_v[i] ? dly[i].on_dly : dly[i].off_dly;
            if (raw_v[i] == work_bit[i]) begin
                next_cnt[i] = DLY_RST;
            end else if (lim == DLY_RST) begin
                next_work_bit[i] = raw_v[i];
            end else if (unit_tick) begin
                if (cnt[i] + DLY_ONE >= lim) begin
                    next_work_bit[i] = raw_v[i];
                    next_cnt[i] = DLY_RST;
                end else begin
                    next_cnt[i] = cnt[i] + DLY_ONE;
                end
            end
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            work_bit <= '0;
            for (int i = 0; i < WB_N; i++) begin
                cnt[i] <= DLY_RST;
            end
        end else begin
            work_bit <= next_work_bit;
            cnt <= next_cnt;
        end
    end

    // ----------------------------------------------------------------
    // Event slots, banks and outputs
    // ----------------------------------------------------------------
    logic [EV_N-1:0] next_event_slot, next_assign_visible;
    logic [2:0] next_bank_no, next_alarm_assigned;
    logic [1:0] next_ctrl_out;
    logic next_bank_sel_en, next_aux_out, any_out_wb;
    logic [OUT_N-1:0] out_v;
    always_comb begin
        any_out_wb = 1'b0;
        for (int k = 0; k < OUT_N; k++) begin
            out_v[k] = (outsel[k] != 4'h0) && work_bit[3'(outsel[k] - OUT_WB_FIRST)];
            any_out_wb = any_out_wb | (outsel[k] != 4'h0);
        end
        next_ctrl_out = out_v[1:0];
        next_aux_out = out_v[2];
        next_alarm_assigned = {3{any_out_wb}};
        for (int s = 0; s < EV_N; s++) begin
            next_event_slot[s] = slot_bit(evdata[s], ev_clean, work_bit);
            next_assign_visible[s] = (s >= 2) || !no_ev12 || (evdata[s] != EVDATA_RST[4*s+:4]);
        end
        next_bank_no = 3'h0;
        for (int k = 0; k < 3; k++) begin
            next_bank_no[k] = (2'(k) < bank_count) && event_slot[k];
        end
        next_bank_sel_en = (bank_count != 2'h0) && no_ev12
                           && (evdata[0] >= EV_WB_FIRST || evdata[1] >= EV_WB_FIRST);
        status_word = {15'h0000, bank_no, alarm_assigned[0], bank_sel_en, event_slot, work_bit};
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            event_slot <= '0;
            assign_visible <= '0;
            bank_no <= 3'h0;
            bank_sel_en <= 1'b0;
            ctrl_out <= 2'h0;
            aux_out <= 1'b0;
            alarm_assigned <= 3'h0;
        end else begin
            event_slot <= next_event_slot;
            assign_visible <= next_assign_visible;
            bank_no <= next_bank_no;
            bank_sel_en <= next_bank_sel_en;
            ctrl_out <= next_ctrl_out;
            aux_out <= next_aux_out;
            alarm_assigned <= next_alarm_assigned;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_comm_req;
        psel && penable && !pready && pwrite && paddr == OFF_EVFUNC && any_wb_slot
        && (wnib[0] == FUNC_COMM_WR || wnib[1] == FUNC_COMM_WR);
    endsequence
    sequence s_err_answer;
        pready && pslverr ##1 evfunc == $past(evfunc);
    endsequence
    property p_comm_refuse;
        s_comm_req |=> s_err_answer;
    endproperty
    a_comm_refuse: assert property (p_comm_refuse) else $error("comm write control accepted");
    property p_on_hold;
        raw_v[0] && !work_bit[0] && dly[0].on_dly != DLY_RST && !unit_tick |=> !work_bit[0];
    endproperty
    a_on_hold: assert property (p_on_hold) else $error("output rose before on delay");
    property p_off_hold;
        !raw_v[0] && work_bit[0] && dly[0].off_dly != DLY_RST && !unit_tick |=> work_bit[0];
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("output fell before off delay");
    property p_zero_pass;
        raw_v[0] != work_bit[0] && (raw_v[0] ? dly[0].on_dly : dly[0].off_dly) == DLY_RST
        |=> work_bit[0] == $past(raw_v[0]);
    endproperty
    a_zero_pass: assert property (p_zero_pass) else $error("zero delay did not pass edge");
    property p_reset_vals;
        first_cycle |-> !time_unit && bank_count == 2'h0 && dly[0].on_dly == DLY_RST;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad settings after reset");
    property p_bank_limit;
        bank_count <= (two_ev ? BANK_MAX_TWO : BANK_MAX);
    endproperty
    a_bank_limit: assert property (p_bank_limit) else $error("bank count out of range");
    property p_bank_sel;
        bank_count != 2'h0 && no_ev12 && evdata[1] >= EV_WB_FIRST |=> bank_sel_en;
    endproperty
    a_bank_sel: assert property (p_bank_sel) else $error("bank select not enabled");
    property p_slot_ext;
        evdata[2] == EV_EXT_FIRST |=> event_slot[2] == $past(ev_clean[0]);
    endproperty
    a_slot_ext: assert property (p_slot_ext) else $error("slot did not follow event input");
    property p_visible;
        evdata[0] != EVDATA_RST[3:0] |=> assign_visible[0];
    endproperty
    a_visible: assert property (p_visible) else $error("changed slot not visible");
    property p_alarm;
        outsel[2] != 4'h0 |=> alarm_assigned == 3'h7;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarms not marked assigned");
    property p_restart;
        raw_v[0] == work_bit[0] |=> cnt[0] == DLY_RST;
    endproperty
    a_restart: assert property (p_restart) else $error("delay count not restarted");
endmodule : wbdelay_core
`default_nettype wire

// >>> rtl/wbdelay_pkg.sv
// Constants, register map and carrier types of the work-bit delay and event routing block.
package wbdelay_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned TICK_SEC_S = 1;
    localparam int unsigned SEC_CYCLES_DEF = CLK_HZ * TICK_SEC_S;
    localparam int SEC_CNT_W = 26;
    localparam logic [5:0] MIN_SECS = 6'h3C;
    localparam int DLY_W = 14;
    localparam logic [DLY_W-1:0] DLY_MAX = 14'h270F;
    localparam logic [DLY_W-1:0] DLY_RST = 14'h0000;
    localparam logic [DLY_W-1:0] DLY_ONE = 14'h0001;
    // ----------------------------------------------------------------
    // Sizes and codes
    // ----------------------------------------------------------------
    localparam int WB_N = 8;
    localparam int EV_N = 4;
    localparam int OUT_N = 3;
    localparam int COND_N = 21;
    localparam logic [3:0] EV_NONE = 4'h0;
    localparam logic [3:0] EV_EXT_FIRST = 4'h1;
    localparam logic [3:0] EV_WB_FIRST = 4'h5;
    localparam logic [3:0] EV_WB_LAST = 4'hC;
    localparam logic [15:0] EVDATA_RST = 16'h4321;
    localparam logic [3:0] FUNC_COMM_WR = 4'h1;
    localparam logic [3:0] OUT_WB_LAST = 4'h8;
    localparam logic [3:0] OUT_WB_FIRST = 4'h1;
    localparam logic [5:0] SRC_ON = 6'h01;
    localparam logic [5:0] SRC_PWR = 6'h02;
    localparam logic [5:0] SRC_EV_FIRST = 6'h03;
    localparam logic [5:0] SRC_COND_FIRST = 6'h07;
    localparam logic [5:0] SRC_WB_FIRST = 6'h1C;
    localparam logic [5:0] SRC_WB_LAST = 6'h23;
    localparam logic [1:0] BANK_MAX = 2'h3;
    localparam logic [1:0] BANK_MAX_TWO = 2'h2;
    // ----------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_EVDATA = 12'h004;
    localparam logic [11:0] OFF_EVFUNC = 12'h008;
    localparam logic [11:0] OFF_OUTSEL = 12'h00C;
    localparam logic [11:0] OFF_STATUS = 12'h010;
    localparam logic [11:0] OFF_CFG = 12'h040;
    localparam logic [11:0] OFF_DLY = 12'h060;
    localparam logic [11:0] OFF_BLOCK_MASK = 12'hFE3;
    localparam int CTRL_UNIT = 0;
    localparam int CTRL_BANK_LSB = 1;
    localparam int CTRL_NOEV12 = 3;
    localparam int CTRL_TWOEV = 4;
    localparam int ST_SLOT_LSB = 8;
    localparam int ST_BANKSEL = 12;
    localparam int ST_ALARM = 13;
    localparam int ST_BANK_LSB = 14;
    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {OP_OFF, OP_AB_OR_CD, OP_AC_AND_BD, OP_ANY, OP_ALL} op_e;
    typedef struct packed {
        logic out_nc;
        logic [3:0] in_nc;
        logic [5:0] sel_d;
        logic [5:0] sel_c;
        logic [5:0] sel_b;
        logic [5:0] sel_a;
        op_e op;
    } wb_cfg_s;
    typedef struct packed {
        logic [1:0] rsv_hi;
        logic [DLY_W-1:0] off_dly;
        logic [1:0] rsv_lo;
        logic [DLY_W-1:0] on_dly;
    } wb_dly_s;
endpackage : wbdelay_pkg

// >>> tb/tb_wbdelay_core.sv
// Self-checking testbench of the work-bit delay and event routing block.
`timescale 1ns/1ps
`default_nettype none
module tb_wbdelay_core import wbdelay_pkg::*;;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err, bank_sel_en, aux_out;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [EV_N-1:0] ev_pin = '0, event_slot, assign_visible;
    logic [COND_N-1:0] cond_in = '0;
    logic [WB_N-1:0] work_bit;
    logic [2:0] bank_no, alarm_assigned;
    logic [1:0] ctrl_out;
    int n_errors = 0, samples_checked = 0;
    always #12.5 clk = ~clk;
    // A 20-cycle tick keeps second and minute delays short enough to simulate.
    wbdelay_core #(.SEC_CYCLES(20)) DUT (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ev_pin(ev_pin),
        .cond_in(cond_in), .work_bit(work_bit), .event_slot(event_slot), .bank_no(bank_no),
        .bank_sel_en(bank_sel_en), .assign_visible(assign_visible), .ctrl_out(ctrl_out), .aux_out(aux_out),
        .alarm_assigned(alarm_assigned));
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wait_cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : wait_cyc
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (n >= 20) n_errors++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, OFF_DLY, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset done");
    endtask : t_reset
    task automatic t_delay();
        apb(1'b1, OFF_CFG, 32'h0000_003B);
        apb(1'b1, OFF_DLY, 32'h0003_0002);
        cond_in[0] <= 1'b1;
        wait_cyc(15);
        chk(work_bit[0], 1'b0);
        wait_cyc(30);
        chk(work_bit[0], 1'b1);
        cond_in[0] <= 1'b0;
        wait_cyc(35);
        chk(work_bit[0], 1'b1);
        wait_cyc(30);
        chk(work_bit[0], 1'b0);
        cond_in[0] <= 1'b1;
        wait_cyc(10);
        cond_in[0] <= 1'b0;
        wait_cyc(45);
        chk(work_bit[0], 1'b0);
        // Minute base: a seconds count would finish long before the first check.
        apb(1'b1, OFF_CTRL, 32'h1);
        cond_in[0] <= 1'b1;
        wait_cyc(100);
        chk(work_bit[0], 1'b0);
        wait_cyc(2400);
        chk(work_bit[0], 1'b1);
        apb(1'b1, OFF_DLY, 32'h0);
        apb(1'b1, OFF_CTRL, 32'h0);
        cond_in[0] <= 1'b0;
        wait_cyc(3);
        chk(work_bit[0], 1'b0);
        $display("test delay done");
    endtask : t_delay
    task automatic t_route();
        ev_pin[0] <= 1'b1;
        wait_cyc(8);
        chk(event_slot[0], 1'b1);
        apb(1'b1, OFF_EVDATA, 32'h4325);
        wait_cyc(3);
        chk(assign_visible[0], 1'b1);
        chk(event_slot[0], 1'b0);
        cond_in[0] <= 1'b1;
        wait_cyc(4);
        chk(event_slot[0], 1'b1);
        apb(1'b1, OFF_EVFUNC, 32'h1);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, OFF_CTRL, 32'h0A);
        wait_cyc(3);
        chk(bank_sel_en, 1'b1);
        chk(assign_visible[0], 1'b1);
        chk(assign_visible[1], 1'b0);
        apb(1'b1, OFF_CTRL, 32'h16);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, OFF_CTRL, 32'h06);
        chk({31'h0, err}, 32'h0);
        apb(1'b1, OFF_OUTSEL, 32'h101);
        wait_cyc(3);
        chk(alarm_assigned, 3'h7);
        chk(aux_out, 1'b1);
        chk(ctrl_out, 2'h1);
        chk(bank_no, 3'h1);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd, 32'h0000_6101);
        $display("test route done");
    endtask : t_route
    task automatic t_logic();
        apb(1'b1, OFF_CFG + 12'h004, 32'h0944_9039);
        cond_in[3:0] <= 4'h2;
        wait_cyc(3);
        chk(work_bit[1], 1'b1);
        cond_in[3:0] <= 4'h3;
        wait_cyc(3);
        chk(work_bit[1], 1'b0);
        apb(1'b1, OFF_CFG + 12'h004, 32'h0144_903A);
        wait_cyc(3);
        chk(work_bit[1], 1'b1);
        cond_in[3:0] <= 4'h1;
        wait_cyc(3);
        chk(work_bit[1], 1'b0);
        apb(1'b1, OFF_CFG + 12'h004, 32'h8144_903C);
        wait_cyc(3);
        chk(work_bit[1], 1'b1);
        cond_in[3:0] <= 4'hF;
        wait_cyc(3);
        chk(work_bit[1], 1'b0);
        $display("test logic done");
    endtask : t_logic
    initial begin
        wait_cyc(8);
        nrst <= 1'b1;
        t_reset();
        t_delay();
        t_route();
        t_logic();
        end_sim();
    end
    initial begin
        #(25 * 20000);
        n_errors++;
        end_sim();
    end
endmodule : tb_wbdelay_core
`default_nettype wire
